/* rtl/cad_params.svh */
`ifndef CAD_PARAMS_SVH
`define CAD_PARAMS_SVH
// Bus and address widths
`define CAD_CA_W          10
`define CAD_BANK_W        4
`define CAD_ROW_W         14
`define CAD_COL_W         7
`define CAD_MASK_W        16
`define CAD_CHANNELS      2
// Prefetch per access in bits and the resulting page size in bytes
`define CAD_PREFETCH_X16  256
`define CAD_PREFETCH_X8   128
`define CAD_PAGE_BYTES    2048
// Data words per burst in each data mode
`define CAD_BURST_FOUR    5'h08
`define CAD_BURST_TWO     5'h10
// Opcode field values on the falling-edge word, bits 7:6
`define CAD_F76_WRITE     2'h0
`define CAD_F76_WR_SBM    2'h1
`define CAD_F76_WR_DBM    2'h2
`define CAD_F76_WR_TRAIN  2'h3
`define CAD_F76_READ      2'h0
`define CAD_F76_FIFO_LOAD 2'h2
`define CAD_F76_RD_TRAIN  2'h3
`endif

/* rtl/cad_pkg.sv */
package cad_pkg;
    // Decoded command kinds
    typedef enum logic [3:0] {
        CMD_IDLE, CMD_ROW_OPEN, CMD_MODE_WRITE, CMD_READ, CMD_WRITE, CMD_WRITE_SBM,
        CMD_WRITE_DBM, CMD_FIFO_LOAD, CMD_READ_TRAIN, CMD_WRITE_TRAIN, CMD_PRECHARGE,
        CMD_REFRESH, CMD_SELF_REFRESH, CMD_POWER_DOWN, CMD_EXIT, CMD_UNKNOWN
    } cad_cmd_kind_type;

    // Per-channel decoder state
    typedef enum logic [1:0] {DS_CMD, DS_MASK1, DS_MASK2} cad_dec_state_type;

    // Pins of one channel's command port, sampled on command clock edges
    typedef struct packed {
        logic       cke_n;
        logic       bus_inversion_flag_low;
        logic [9:0] cmd_addr_bus;
    } cad_pins_type;

    // One decoded command
    typedef struct packed {
        cad_cmd_kind_type kind;
        logic [3:0]       bank;
        logic [13:0]      row;
        logic [6:0]       col;
        logic [10:0]      col_byte;
        logic             auto_close;
        logic             all_banks;
        logic [3:0]       mode_reg_sel;
        logic [11:0]      mode_reg_value;
        logic [9:0]       fifo_data;
        logic [31:0]      burst_mask_bits;
        logic [4:0]       burst_words;
    } cad_cmd_type;
endpackage

/* rtl/cad_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cad_params.svh"

// Notes on behaviour
// (R1) Capture command bus on both clock edges
// (R2) One command clock pair serves both channels
// (R3) Commands arrive as ten-bit bus packets
// (R4) Two independent sixteen-bit channels, separate decode
// (R5) Burst is 8 words four-level, 16 two-level
// (R6) Host opens a row before bursts
// (R7) Bank and start column from burst command
// (R8) Data on both forwarded data clock edges
// (R9) Four-bit bank field, sixteen banks
// (R10) Column six bits x16, seven bits x8
// (R11) Prefetch 256 bits x16, 128 bits x8
// (R12) Column omits burst bits; fixed order
// (R13) Host refreshes 16k times per 32 ms
// (R14) Width mode latched in reset, then fixed
// (R15) Sixteen independently addressed banks
// (R16) Each burst has an auto-close variant
// (R17) Write masks over command bus, byte/double-byte
// (R18) Page size 2KB per channel
// (R19) Per-channel forwarded data clock times data
// (R20) Single-cycle and multi-cycle commands decoded
// (R21) Mode write: 4-bit select, 12-bit value
// (R22) Inversion flag low inverts the bus
// (R23) Host uses extra idle codes only training
// (R24) Shared refresh code: clock-enable picks self-refresh
// (R25) Only defined opcode bits identify commands
module cad_decoder (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             cmd_clk_true,
    input  wire logic             cmd_clk_comp,
    input  wire cad_pkg::cad_pins_type ca_pins [2],
    input  wire logic             width_x8_strap,
    input  wire logic             bus_inversion,
    input  wire logic             two_level_strobe_mode,
    output var  logic [1:0]       cmd_valid,
    output var  cad_pkg::cad_cmd_type cmd_word [2],
    output var  logic [1:0]       cmd_overrun,
    output var  logic             width_x8
);
    import cad_pkg::*;

    // Byte offset of a column within the 2KB page
    // (R18) page byte address
    function automatic logic [10:0] col_byte_of(input logic [6:0] col, input logic x8);
        // (R11) prefetch sets scaling
        col_byte_of = x8 ? {col[6:0], 4'h0} : {col[5:0], 5'h00};
    endfunction

    // Decode the first command cycle from its rising and falling words
    function automatic cad_cmd_type decode_head(input logic [9:0] r, input logic [9:0] f,
                                                input logic ck_prev, input logic ck_cur,
                                                input logic x8, input logic two_lvl);
        cad_cmd_type c;
        c = '0;
        c.kind = CMD_UNKNOWN;
        // (R9) bank field
        // (R15) one of sixteen banks
        c.bank = r[7:4];
        // (R10) column width per mode
        // (R12) no burst-position bits
        c.col = x8 ? {f[2:0], r[3:0]} : {1'b0, f[1:0], r[3:0]};
        c.col_byte = col_byte_of(c.col, x8);
        // (R8) words on both data edges
        // (R19) per-channel data clock paces
        // (R5) words per burst
        c.burst_words = two_lvl ? `CAD_BURST_TWO : `CAD_BURST_FOUR;
        // (R16) auto-close variant bit
        c.auto_close = f[4];
        // (R25) opcode bits only
        case ({ck_prev, ck_cur})
            2'b00: begin
                if (!r[9]) begin
                    c.kind = CMD_ROW_OPEN;
                    c.row = {f[9:0], r[3:0]};
                end else if (r[8]) begin
                    if (f[9]) begin
                        c.kind = CMD_IDLE;
                    end else if (f[8]) begin
                        case (f[7:6])
                            `CAD_F76_READ:      c.kind = f[3] ? CMD_READ : CMD_UNKNOWN;
                            `CAD_F76_FIFO_LOAD: c.kind = CMD_FIFO_LOAD;
                            `CAD_F76_RD_TRAIN:  c.kind = (f[3] && !f[4]) ? CMD_READ_TRAIN : CMD_UNKNOWN;
                            default:            c.kind = CMD_UNKNOWN;
                        endcase
                        c.fifo_data = {f[5:0], r[3:0]};
                    end else begin
                        case (f[7:6])
                            `CAD_F76_WRITE:    c.kind = CMD_WRITE;
                            `CAD_F76_WR_SBM:   c.kind = CMD_WRITE_SBM;
                            `CAD_F76_WR_DBM:   c.kind = CMD_WRITE_DBM;
                            `CAD_F76_WR_TRAIN: c.kind = f[4] ? CMD_UNKNOWN : CMD_WRITE_TRAIN;
                            default:           c.kind = CMD_UNKNOWN;
                        endcase
                        if (!f[3]) begin
                            c.kind = CMD_UNKNOWN;
                        end
                    end
                end else begin
                    case (f[9:8])
                        2'b10: begin
                            // (R21) select and value
                            c.kind = CMD_MODE_WRITE;
                            c.mode_reg_sel = r[7:4];
                            c.mode_reg_value = {f[7:0], r[3:0]};
                        end
                        2'b00: begin
                            c.kind = CMD_PRECHARGE;
                            c.all_banks = f[4];
                        end
                        2'b01: begin
                            c.kind = CMD_REFRESH;
                            c.all_banks = f[4];
                        end
                        default: c.kind = CMD_IDLE;
                    endcase
                end
            end
            // (R24) clock-enable picks self-refresh
            2'b01:   c.kind = (r[9:8] == 2'b10 && f[9:8] == 2'b01) ? CMD_SELF_REFRESH : CMD_POWER_DOWN;
            2'b10:   c.kind = CMD_EXIT;
            default: c.kind = CMD_IDLE;
        endcase
        return c;
    endfunction

    // ---------------- Command-clock domain ----------------
    logic [1:0]   lrst_s_r, lrst_s_nxt;
    logic [2:0]   cfg_s1_r, cfg_s1_nxt, cfg_s2_r, cfg_s2_nxt;
    cad_pins_type rise1_r [2];
    cad_pins_type rise1_nxt [2];
    cad_pins_type fall1_r [2];
    cad_pins_type fall1_nxt [2];
    cad_pins_type prise_r [2];
    cad_pins_type prise_nxt [2];
    cad_pins_type pfall_r [2];
    cad_pins_type pfall_nxt [2];
    logic         link_rst;

    assign link_rst = lrst_s_r[1];

    // Falling-edge capture clocked by the complementary clock, half a cycle ahead of use
    // (R1) falling word capture
    always_comb begin
        fall1_nxt = ca_pins;
    end

    always_ff @(posedge cmd_clk_comp) begin
        fall1_r <= fall1_nxt;
    end

    // Rising capture, second stage for both words, reset and config synchronisers
    // (R2) shared command clock
    always_comb begin
        lrst_s_nxt = {lrst_s_r[0], rst};
        cfg_s1_nxt = {width_x8, bus_inversion, two_level_strobe_mode};
        cfg_s2_nxt = cfg_s1_r;
        rise1_nxt  = ca_pins;
        prise_nxt  = rise1_r;
        pfall_nxt  = fall1_r;
    end

    always_ff @(posedge cmd_clk_true) begin
        lrst_s_r <= lrst_s_nxt;
        cfg_s1_r <= cfg_s1_nxt;
        cfg_s2_r <= cfg_s2_nxt;
        rise1_r  <= rise1_nxt;
        prise_r  <= prise_nxt;
        pfall_r  <= pfall_nxt;
    end

    // Decoder per channel; commands are handed to the system clock by a toggle handshake
    cad_dec_state_type st_r [2];
    cad_dec_state_type st_nxt [2];
    cad_cmd_type       hold_r [2];
    cad_cmd_type       hold_nxt [2];
    cad_cmd_type       xfer_r [2];
    cad_cmd_type       xfer_nxt [2];
    logic [1:0]        cke_prev_r, cke_prev_nxt;
    logic [1:0]        req_r, req_nxt;
    logic [1:0]        ack_s1_r, ack_s1_nxt, ack_s2_r, ack_s2_nxt;
    logic [1:0]        ovr_r, ovr_nxt;
    // System-side toggle and ack, declared here since the link side reads the ack
    logic [1:0]        req_s1_r, req_s1_nxt, req_s2_r, req_s2_nxt, req_ack_r, req_ack_nxt;

    always_comb begin
        logic [9:0]  rw;
        logic [9:0]  fw;
        cad_cmd_type head;
        logic        done;
        rw = '0;
        fw = '0;
        head = '0;
        done = 1'b0;
        st_nxt = st_r;
        hold_nxt = hold_r;
        xfer_nxt = xfer_r;
        req_nxt = req_r;
        ovr_nxt = ovr_r;
        ack_s1_nxt = req_ack_r;
        ack_s2_nxt = ack_s1_r;
        // (R4) independent channel decode
        for (int ch = 0; ch < `CAD_CHANNELS; ch++) begin
            // (R22) logical value from inverted bus
            rw = prise_r[ch].cmd_addr_bus;
            fw = pfall_r[ch].cmd_addr_bus;
            if (cfg_s2_r[1] && !prise_r[ch].bus_inversion_flag_low) begin
                rw = ~rw;
            end
            if (cfg_s2_r[1] && !pfall_r[ch].bus_inversion_flag_low) begin
                fw = ~fw;
            end
            cke_prev_nxt[ch] = prise_r[ch].cke_n;
            done = 1'b0;
            // (R20) multi-cycle mask sequencing
            case (st_r[ch])
                DS_CMD: begin
                    // (R3) packet from ten-bit words
                    head = decode_head(rw, fw, cke_prev_r[ch], prise_r[ch].cke_n, cfg_s2_r[2], cfg_s2_r[0]);
                    hold_nxt[ch] = head;
                    if (head.kind == CMD_WRITE_SBM) begin
                        st_nxt[ch] = DS_MASK1;
                    end else if (head.kind == CMD_WRITE_DBM) begin
                        st_nxt[ch] = DS_MASK2;
                    end else begin
                        done = (head.kind != CMD_IDLE);
                    end
                end
                // (R17) byte 0 mask, single-byte granularity
                DS_MASK1: begin
                    hold_nxt[ch].burst_mask_bits[15:0] = {fw[7:0], rw[7:0]};
                    st_nxt[ch] = DS_MASK2;
                end
                // (R17) last mask cycle
                DS_MASK2: begin
                    if (hold_r[ch].kind == CMD_WRITE_SBM) begin
                        hold_nxt[ch].burst_mask_bits[31:16] = {fw[7:0], rw[7:0]};
                    end else begin
                        hold_nxt[ch].burst_mask_bits[15:0] = {fw[7:0], rw[7:0]};
                    end
                    st_nxt[ch] = DS_CMD;
                    done = 1'b1;
                end
                default: st_nxt[ch] = DS_CMD;
            endcase
            // A command finishing while the previous is still in flight is dropped and flagged
            if (done) begin
                if (req_r[ch] == ack_s2_r[ch]) begin
                    xfer_nxt[ch] = hold_nxt[ch];
                    req_nxt[ch] = ~req_r[ch];
                end else begin
                    ovr_nxt[ch] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge cmd_clk_true) begin
        if (link_rst) begin
            st_r       <= '{DS_CMD, DS_CMD};
            hold_r     <= '{default: '0};
            xfer_r     <= '{default: '0};
            cke_prev_r <= cke_prev_nxt; // Track the pin so release shows no false exit
            req_r      <= 2'h0;
            ack_s1_r   <= 2'h0;
            ack_s2_r   <= 2'h0;
            ovr_r      <= 2'h0;
        end else begin
            st_r       <= st_nxt;
            hold_r     <= hold_nxt;
            xfer_r     <= xfer_nxt;
            cke_prev_r <= cke_prev_nxt;
            req_r      <= req_nxt;
            ack_s1_r   <= ack_s1_nxt;
            ack_s2_r   <= ack_s2_nxt;
            ovr_r      <= ovr_nxt;
        end
    end

    // ---------------- System-clock domain ----------------
    logic        strap_s1_r, strap_s1_nxt, strap_s2_r, strap_s2_nxt;
    logic        width_x8_nxt;
    logic [1:0]  ovr_s1_r, ovr_s1_nxt;
    logic [1:0]  cmd_valid_nxt, cmd_overrun_nxt;
    cad_cmd_type cmd_word_nxt [2];

    // Strap and handshake receive; the word is stable while the toggle differs from its ack
    always_comb begin
        strap_s1_nxt = width_x8_strap;
        strap_s2_nxt = strap_s1_r;
        // (R14) latched only while reset held
        width_x8_nxt = rst ? strap_s2_r : width_x8;
        req_s1_nxt = req_r;
        req_s2_nxt = req_s1_r;
        req_ack_nxt = req_s2_r;
        ovr_s1_nxt = ovr_r;
        cmd_overrun_nxt = ovr_s1_r;
        cmd_word_nxt = cmd_word;
        for (int ch = 0; ch < `CAD_CHANNELS; ch++) begin
            cmd_valid_nxt[ch] = (req_s2_r[ch] != req_ack_r[ch]);
            if (cmd_valid_nxt[ch]) begin
                // (R7) bank and column delivered
                cmd_word_nxt[ch] = xfer_r[ch];
            end
        end
    end

    always_ff @(posedge mclk) begin
        strap_s1_r <= strap_s1_nxt;
        strap_s2_r <= strap_s2_nxt;
        width_x8   <= width_x8_nxt;
        if (rst) begin
            req_s1_r    <= 2'h0;
            req_s2_r    <= 2'h0;
            req_ack_r   <= 2'h0;
            ovr_s1_r    <= 2'h0;
            cmd_overrun <= 2'h0;
            cmd_valid   <= 2'h0;
            cmd_word    <= '{default: '0};
        end else begin
            req_s1_r    <= req_s1_nxt;
            req_s2_r    <= req_s2_nxt;
            req_ack_r   <= req_ack_nxt;
            ovr_s1_r    <= ovr_s1_nxt;
            cmd_overrun <= cmd_overrun_nxt;
            cmd_valid   <= cmd_valid_nxt;
            cmd_word    <= cmd_word_nxt;
        end
    end
endmodule // cad_decoder

`default_nettype wire

/* dv/cad_decoder_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cad_decoder_chk
    import cad_pkg::*;
(
    input wire logic         mclk,
    input wire logic         rst,
    input wire logic         cmd_clk_true,
    input wire logic         cmd_clk_comp,
    input wire cad_pins_type ca_pins [2],
    input wire logic         width_x8_strap,
    input wire logic         bus_inversion,
    input wire logic         two_level_strobe_mode,
    input wire logic [1:0]   cmd_valid,
    input wire cad_cmd_type  cmd_word [2],
    input wire logic [1:0]   cmd_overrun,
    input wire logic         width_x8
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Burst commands on channel zero
    wire logic b0 = cmd_word[0].kind inside {CMD_READ, CMD_WRITE, CMD_WRITE_SBM, CMD_WRITE_DBM};

    a_valid_pulse: assert property (cmd_valid != 2'h0 |=> (cmd_valid & $past(cmd_valid)) == 2'h0)
        else $error("valid lasted more than one cycle");
    a_word_holds: assert property (!cmd_valid[0] |-> $stable(cmd_word[0]))
        else $error("command word moved without valid");
    a_kind_set: assert property (cmd_valid[0] |-> cmd_word[0].kind != CMD_IDLE)
        else $error("valid with idle kind");
    a_burst_len: assert property (cmd_valid[0] && b0 |->
        cmd_word[0].burst_words == (two_level_strobe_mode ? 5'h10 : 5'h08))
        else $error("burst length wrong");
    a_col_narrow: assert property (cmd_valid[0] && b0 && !width_x8 |-> !cmd_word[0].col[6])
        else $error("seventh column bit in x16");
    a_col_bytes: assert property (cmd_valid[0] && b0 |-> cmd_word[0].col_byte ==
        (width_x8 ? {cmd_word[0].col, 4'h0} : {cmd_word[0].col[5:0], 5'h00}))
        else $error("column byte offset wrong");
    a_width_frozen: assert property (!$past(rst) |-> $stable(width_x8))
        else $error("organisation changed outside reset");
    a_overrun_kept: assert property (cmd_overrun[0] |=> cmd_overrun[0])
        else $error("overrun flag cleared");
    // Main scenarios reached
    c_ch0: cover property (cmd_valid[0]);
    c_ch1: cover property (cmd_valid[1]);
    c_over: cover property (cmd_overrun[0]);
endmodule // cad_decoder_chk
bind cad_decoder cad_decoder_chk u_cad_decoder_chk (.mclk(mclk), .rst(rst), .cmd_clk_true(cmd_clk_true),
    .cmd_clk_comp(cmd_clk_comp), .ca_pins(ca_pins), .width_x8_strap(width_x8_strap),
    .bus_inversion(bus_inversion), .two_level_strobe_mode(two_level_strobe_mode), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_overrun(cmd_overrun), .width_x8(width_x8));
`default_nettype wire

/* dv/cad_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cad_host_model
    import cad_pkg::*;
(
    input  wire logic         bus_inversion,
    output var  logic         cmd_clk_true,
    output var  cad_pins_type ca_pins [2]
);
    // one free running clock for both channels
    initial cmd_clk_true = 1'b0;
    always #16 cmd_clk_true = ~cmd_clk_true;
    // Start idle with the flag high, so enabling inversion cannot turn idle into a row open
    initial ca_pins = '{2{12'h7ff}};
    // physical levels inverted when flag low
    function automatic cad_pins_type phys(input logic cke, input logic fl, input logic [9:0] w);
        phys = {cke, fl, (bus_inversion && !fl) ? ~w : w};
    endfunction
    // packet word pair, changed a quarter period after each edge
    task automatic send(input int ch, input logic [9:0] r, input logic [9:0] f, input logic cke, input logic fl);
        @(negedge cmd_clk_true);
        #8 ca_pins[ch] = phys(cke, fl, r);
        @(posedge cmd_clk_true);
        #8 ca_pins[ch] = phys(cke, fl, f);
    endtask
    // the full refresh cadence is far longer than a run; single refreshes only
    // only the first idle code, low bits flipping each edge
    task automatic idle(input int ch, input logic cke);
        send(ch, 10'h355, 10'h3aa, cke, 1'b1);
    endtask
endmodule // cad_host_model
`default_nettype wire

/* dv/cad_decoder_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cad_decoder_test;
    import cad_pkg::*;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic         strap = 1'b0;
    logic         inv = 1'b0;
    logic         two = 1'b0;
    logic         cke = 1'b0;
    logic         ck_t;
    cad_pins_type ca_pins [2];
    logic [1:0]   cmd_valid;
    logic [1:0]   cmd_overrun;
    cad_cmd_type  cmd_word [2];
    cad_cmd_type  seen;
    logic         width_x8;
    int           mismatches = 0;
    int           num_checks = 0;

    // Free running system clock
    always #50 mclk = ~mclk;
    cad_host_model u_cad_host_model (.bus_inversion(inv), .cmd_clk_true(ck_t), .ca_pins(ca_pins));
    cad_decoder u_cad_decoder (.mclk(mclk), .rst(rst), .cmd_clk_true(ck_t), .cmd_clk_comp(~ck_t),
        .ca_pins(ca_pins), .width_x8_strap(strap), .bus_inversion(inv), .two_level_strobe_mode(two),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_overrun(cmd_overrun), .width_x8(width_x8));

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Strap is set while reset is held; s_x8 later moves it outside reset
    task automatic do_reset(input logic s);
        logic [1:0] any;
        any = 2'h0;
        @(negedge mclk);
        rst = 1'b1;
        strap = s;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        // No command may appear from reset alone
        repeat (20) begin
            @(negedge mclk);
            any = any | cmd_valid;
        end
        chk("quiet_after_reset", any, 2'h0);
    endtask
    task automatic cmd(input int ch, input logic [9:0] r, input logic [9:0] f, input logic fl = 1'b1);
        u_cad_host_model.send(ch, r, f, cke, fl);
    endtask
    // Idle the bus, then watch a fixed window that also spaces commands apart
    task automatic fin(input int ch, input logic want);
        logic hit;
        hit = 1'b0;
        u_cad_host_model.idle(ch, cke);
        repeat (30) begin
            @(negedge mclk);
            if (cmd_valid[ch] === 1'b1 && !hit) begin
                hit = 1'b1;
                seen = cmd_word[ch];
            end
        end
        chk("cmd_valid", hit, want);
    endtask
    task automatic s_row_open;
        inv = 1'b1;
        repeat (10) @(negedge mclk);
        cmd(1, 10'h0a5, 10'h2b7, 1'b0);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_ROW_OPEN);
        chk("bank", seen.bank, 4'ha);
        chk("row", seen.row, 14'h2b75);
        inv = 1'b0;
    endtask
    // bank a was opened just before
    task automatic s_read;
        cmd(1, 10'h3a9, 10'h11a);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_READ);
        chk("auto_close", seen.auto_close, 1'b1);
        chk("col", seen.col, 7'h29);
        chk("col_byte", seen.col_byte, 11'h520);
        chk("burst", seen.burst_words, 5'h08);
    endtask
    task automatic s_writes;
        cad_cmd_kind_type kd [3] = '{CMD_WRITE, CMD_WRITE_SBM, CMD_WRITE_DBM};
        logic [31:0] mk [3] = '{32'h0, 32'ha55ac33c, 32'h0000c33c};
        two = 1'b1;
        repeat (10) @(negedge mclk);
        cmd(0, 10'h025, 10'h2b7);
        fin(0, 1'b1);
        chk("bank", seen.bank, 4'h2);
        for (int k = 0; k < 3; k++) begin
            cmd(0, 10'h326, {2'b00, 2'(k), 6'h09});
            for (int j = 0; j < ((k == 1) ? 2 : k / 2); j++) cmd(0, j ? 10'h35a : 10'h33c, j ? 10'h3a5 : 10'h3c3);
            fin(0, 1'b1);
            chk("kind", seen.kind, kd[k]);
            if (k > 0) chk("mask", seen.burst_mask_bits, mk[k]);
            chk("burst", seen.burst_words, 5'h10);
            chk("col", seen.col, 7'h16);
        end
        two = 1'b0;
    endtask
    task automatic s_mode;
        cmd(0, 10'h27b, 10'h25e);
        fin(0, 1'b1);
        chk("sel", seen.mode_reg_sel, 4'h7);
        chk("value", seen.mode_reg_value, 12'h5eb);
    endtask
    task automatic s_power;
        cmd(0, 10'h200, 10'h110);
        fin(0, 1'b1);
        chk("kind", seen.kind, CMD_REFRESH);
        chk("all_banks", seen.all_banks, 1'b1);
        cke = 1'b1;
        cmd(0, 10'h200, 10'h110);
        fin(0, 1'b1);
        chk("kind", seen.kind, CMD_SELF_REFRESH);
        cke = 1'b0;
        fin(0, 1'b1);
        chk("kind", seen.kind, CMD_EXIT);
        cke = 1'b1;
        cmd(0, 10'h300, 10'h300);
        fin(0, 1'b1);
        chk("kind", seen.kind, CMD_POWER_DOWN);
        cke = 1'b0;
        fin(0, 1'b1);
        chk("kind", seen.kind, CMD_EXIT);
    endtask
    task automatic s_refuse;
        cmd(1, 10'h300, 10'h300);
        fin(1, 1'b0);
        cmd(1, 10'h3a9, 10'h110);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_UNKNOWN);
    endtask
    // Precharge, FIFO load and the two training commands
    task automatic s_others;
        cmd(1, 10'h2c0, 10'h000);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_PRECHARGE);
        chk("bank", seen.bank, 4'hc);
        chk("all_banks", seen.all_banks, 1'b0);
        cmd(1, 10'h35a, 10'h1a7);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_FIFO_LOAD);
        chk("fifo_data", seen.fifo_data, 10'h27a);
        cmd(1, 10'h300, 10'h1c8);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_READ_TRAIN);
        cmd(1, 10'h300, 10'h0c8);
        fin(1, 1'b1);
        chk("kind", seen.kind, CMD_WRITE_TRAIN);
    endtask
    task automatic s_overrun;
        cmd(0, 10'h0a5, 10'h2b7);
        cmd(0, 10'h0a5, 10'h2b7);
        fin(0, 1'b1);
        chk("overrun0", cmd_overrun[0], 1'b1);
        chk("overrun1", cmd_overrun[1], 1'b0);
    endtask
    task automatic s_x8;
        do_reset(1'b1);
        strap = 1'b0;
        cmd(0, 10'h0a5, 10'h2b7);
        fin(0, 1'b1);
        cmd(0, 10'h3a9, 10'h10d);
        fin(0, 1'b1);
        chk("width_x8", width_x8, 1'b1);
        chk("col", seen.col, 7'h59);
        chk("col_byte", seen.col_byte, 11'h590);
    endtask
    // Main sequence
    initial begin
        do_reset(1'b0);
        s_row_open();
        s_read();
        s_writes();
        s_mode();
        s_power();
        s_refuse();
        s_others();
        s_overrun();
        s_x8();
        close_out();
    end
    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        mismatches++;
        close_out();
    end
endmodule // cad_decoder_test
`default_nettype wire
